// ===== prc_regs.svh
/*
 * Register offsets, field positions, reset values and timing constants
 * for the power, reset and charger control block.
 * Assumes inclusion by bare name from the design file and the bench.
 */
`ifndef PRC_REGS_SVH
`define PRC_REGS_SVH

// ********************************
// register offsets (byte addresses)
// ********************************
`define REG_CTRL_ADDR 8'h00
`define REG_STATUS_ADDR 8'h04
`define REG_LED_ADDR 8'h08
`define REG_WDOG_ADDR 8'h0C
`define REG_WDOG_KICK_ADDR 8'h10
`define REG_RESET_CAUSE_ADDR 8'h14
`define REG_CHG_CFG_ADDR 8'h18
`define REG_ID_ADDR 8'h1C

// ********************************
// control register fields
// ********************************
`define CTRL_REG_LATCH_BIT 0
`define CTRL_FW_RUNNING_BIT 1
`define CTRL_SMPS_FW_BIT 2
`define CTRL_WDOG_EN_BIT 3
`define CTRL_CLK_CONFIGURED_BIT 4
`define CTRL_CHG_EN_BIT 5
`define CTRL_WIDTH 6
`define CTRL_RESET 6'h20

// ********************************
// status register fields
// ********************************
`define STAT_SMPS_PIN_BIT 0
`define STAT_LIN_PIN_BIT 1
`define STAT_CHG_PRESENT_BIT 2
`define STAT_SMPS_ON_BIT 3
`define STAT_LIN_ON_BIT 4
`define STAT_STATE_LO 5
`define STAT_STATE_HI 7
`define STAT_WARM_BIT 8
`define STAT_BAT_LOW_BIT 9
`define STAT_BAT_FLOAT_BIT 10

// ********************************
// led register fields
// ********************************
`define LED0_FW_BIT 0
`define LED1_FW_BIT 1

// ********************************
// reset cause fields, cleared by writing one
// ********************************
`define CAUSE_PIN_BIT 0
`define CAUSE_POR_BIT 1
`define CAUSE_BREAK_BIT 2
`define CAUSE_WDOG_BIT 3
`define CAUSE_WIDTH 4

// ********************************
// timing
// ********************************
`define CLK_MHZ 100
`define WDOG_RESET 16'hFFFF
`define PULSE_PERIOD_MS 1000
`define PULSE_ON_MS 10
`define RST_PULSE_CYCLES 8'h10
`define ID_VALUE 32'h0000_5A01

`endif

// ===== prc_pkg.sv
/*
 * Types shared by the power, reset and charger control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package prc_pkg;

    // charger states, encoded as seen in the status register
    typedef enum logic [2:0] {
        CHG_OFF = 3'b000,
        CHG_TRICKLE = 3'b001,
        CHG_FAST_CC = 3'b010,
        CHG_FAST_CV = 3'b011,
        CHG_STANDBY = 3'b100
    } chg_state_t;

endpackage

// ===== power_reset_charger_control.sv
/*
 * Power, reset and charger supervisor: regulator enables with firmware
 * latch, charger state machine, open-drain indicator pads and the
 * merged internal reset.
 * Assumes analog comparators deliver digital levels asynchronous to
 * ref_clk, and a slow low-frequency clock tick arrives as a pin level.
 */
// How it works
// - high enable pin drives switch-mode regulator; low pin drives both linear ones.
// - both enable pins are active high; pads pull them low when floating.
// - pins boot the chip; firmware latch then holds regulators on.
// - live level of the high enable pin is readable by firmware.
// - charger goes off whenever its supply disappears.
// - supply present and battery under low threshold gives trickle charge.
// - battery above low threshold moves charger to constant-current fast charge.
// - battery at float voltage moves charger to constant-voltage charge.
// - full battery sits in standby; drop past margin returns to fast charge.
// - supply present and battery not full lights the charge indicator.
// - until firmware runs the indicator pulses at low duty cycle.
// - charger supply presence is reported in a status bit.
// - two firmware pads, pad 0 also driven by charger, open-drain only.
// - internal reset comes from pin, power-on, uart break or watchdog.
// - reset pin is filtered by the slow clock, taking 2.0 to 3.0 ms.
// - power-on reset asserts below lower threshold, releases above upper.
// - during reset bidirectional pins are inputs and outputs float.
// - after reset clocks run at the safe slow setting until configured.
// - during reset each pad gets its fixed pull-up or pull-down.
// - warm reset keeps rate and ram; cold reset keeps neither.
// - switch-mode regulator enable is pin OR firmware OR charger.
`timescale 1ns/1ps
`include "prc_regs.svh"

module power_reset_charger_control
    import prc_pkg::*;
#(
    parameter int WDOG_WIDTH = 16,
    parameter int PULSE_PERIOD_CYCLES = `PULSE_PERIOD_MS * 1000 * `CLK_MHZ,
    parameter int PULSE_ON_CYCLES = `PULSE_ON_MS * 1000 * `CLK_MHZ,
    // slow clock ticks counted before the asserting one; 2.0..3.0 ms at a 1 kHz tick
    parameter int RST_FILTER_TICKS = 2,
    parameter logic [31:0] ID_VALUE = `ID_VALUE  // arbitrary value
) (
    // clock and power-on reset
    input wire logic ref_clk,
    input wire logic rst,
    // regulator enable pins
    input wire logic smps_enable_pin,
    input wire logic linear_reg_enable_pin,
    // charger comparators
    input wire logic charger_supply_in,
    input wire logic battery_below_low,
    input wire logic battery_at_float,
    input wire logic battery_below_recharge,
    // reset sources
    input wire logic rst_pin_n,
    input wire logic slow_clk_tick,
    input wire logic core_supply_low,
    input wire logic core_supply_high,
    input wire logic uart_break,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // regulator and charger controls
    output logic smps_enable,
    output logic linear_reg_enable,
    output logic audio_reg_enable,
    output logic charge_trickle,
    output logic charge_cc,
    output logic charge_cv,
    // indicator pads, open drain: oe low means pad pulled down
    output logic indicator_pad_0_out,
    output logic indicator_pad_0_oe_n,
    output logic indicator_pad_1_out,
    output logic indicator_pad_1_oe_n,
    // reset state and pin conditioning
    output logic chip_reset,
    output logic warm_reset,
    output logic pads_in_reset,
    output logic safe_clock
);

    // ********************************
    // synchronisers
    // ********************************
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    assign async_in = {slow_clk_tick, uart_break, core_supply_high, core_supply_low,
                       rst_pin_n, battery_below_recharge, battery_at_float,
                       battery_below_low, charger_supply_in, linear_reg_enable_pin};
    logic smps_pin1_q;
    logic smps_pin2_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            // reset pin idles high, so no false filter start after reset
            sync1_q <= 10'h020;
            sync2_q <= 10'h020;
            smps_pin1_q <= 1'b0;
            smps_pin2_q <= 1'b0;
        end else begin
            sync1_q <= async_in;
            sync2_q <= sync1_q;
            smps_pin1_q <= smps_enable_pin;
            smps_pin2_q <= smps_pin1_q;
        end
    end

    logic lin_pin_s, chg_present_s, bat_low_s, bat_float_s, bat_recharge_s;
    logic rst_pin_n_s, core_low_s, core_high_s, break_s, tick_s;
    assign {tick_s, break_s, core_high_s, core_low_s, rst_pin_n_s, bat_recharge_s,
            bat_float_s, bat_low_s, chg_present_s, lin_pin_s} = sync2_q;

    // ********************************
    // registers
    // ********************************
    logic [`CTRL_WIDTH-1:0] ctrl_q;
    logic [1:0] led_fw_q;
    logic [WDOG_WIDTH-1:0] wdog_reload_q;
    logic [WDOG_WIDTH-1:0] wdog_cnt_q;
    logic [`CAUSE_WIDTH-1:0] cause_q;
    logic soft_reset_q;
    chg_state_t state_q, state_d;

    function automatic logic wr_hit(input logic [7:0] a);
        return reg_wr && (reg_addr == a);
    endfunction

    // ********************************
    // merged reset
    // ********************************
    logic por_q;
    logic pin_reset_q;
    logic [7:0] filt_cnt_q;
    logic tick_prev_q;
    logic wdog_expire;
    logic break_prev_q;
    logic break_rise;
    logic [7:0] pulse_cnt_q;
    logic int_reset;
    assign break_rise = break_s && !break_prev_q;
    assign wdog_expire = ctrl_q[`CTRL_WDOG_EN_BIT] && (wdog_cnt_q == '0);

    // hysteresis: assert below low threshold, release only above high
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            por_q <= 1'b1;
        end else if (core_low_s) begin
            por_q <= 1'b1;
        end else if (core_high_s) begin
            por_q <= 1'b0;
        end
    end

    // the pin must stay low over several slow ticks; glitches restart the count
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            filt_cnt_q <= 8'h00;
            pin_reset_q <= 1'b0;
            tick_prev_q <= 1'b0;
        end else begin
            tick_prev_q <= tick_s;
            if (rst_pin_n_s) begin
                filt_cnt_q <= 8'h00;
                pin_reset_q <= 1'b0;
            end else if (tick_s && !tick_prev_q) begin
                if (filt_cnt_q == 8'(RST_FILTER_TICKS)) begin
                    pin_reset_q <= 1'b1;
                end else begin
                    filt_cnt_q <= filt_cnt_q + 8'h01;
                end
            end
        end
    end

    // event sources stretch into a reset pulse of fixed length
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            break_prev_q <= 1'b0;
            pulse_cnt_q <= 8'h00;
        end else begin
            break_prev_q <= break_s;
            if (break_rise || wdog_expire) begin
                pulse_cnt_q <= `RST_PULSE_CYCLES;
            end else if (pulse_cnt_q != 8'h00) begin
                pulse_cnt_q <= pulse_cnt_q - 8'h01;
            end
        end
    end

    assign int_reset = por_q || pin_reset_q || (pulse_cnt_q != 8'h00);

    // ********************************
    // reset cause and warm/cold tracking
    // ********************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cause_q <= 4'h2;
            soft_reset_q <= 1'b0;
        end else begin
            // a new cause wins over a write-one clear in the same cycle
            cause_q <= (cause_q & ~(wr_hit(`REG_RESET_CAUSE_ADDR) ?
                        reg_wdata[`CAUSE_WIDTH-1:0] : 4'h0))
                       | {wdog_expire, break_rise, por_q, pin_reset_q};
            // warm only when no power loss occurred since
            if (por_q) begin
                soft_reset_q <= 1'b0;
            end else if (int_reset) begin
                soft_reset_q <= 1'b1;
            end
        end
    end

    // ********************************
    // control registers
    // ********************************
    always_ff @(posedge ref_clk) begin
        if (rst || int_reset) begin
            ctrl_q <= `CTRL_RESET;
            led_fw_q <= 2'h0;
            wdog_reload_q <= `WDOG_RESET;
        end else begin
            if (wr_hit(`REG_CTRL_ADDR)) begin
                ctrl_q <= reg_wdata[`CTRL_WIDTH-1:0];
            end
            if (wr_hit(`REG_LED_ADDR)) begin
                led_fw_q <= reg_wdata[1:0];
            end
            if (wr_hit(`REG_WDOG_ADDR)) begin
                wdog_reload_q <= reg_wdata[WDOG_WIDTH-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || int_reset) begin
            wdog_cnt_q <= `WDOG_RESET;
        end else if (wr_hit(`REG_WDOG_KICK_ADDR) || !ctrl_q[`CTRL_WDOG_EN_BIT]) begin
            wdog_cnt_q <= wdog_reload_q;
        end else if (wdog_cnt_q != '0) begin
            wdog_cnt_q <= wdog_cnt_q - 1'b1;
        end
    end

    // ********************************
    // charger state machine
    // ********************************
    always_comb begin
        state_d = state_q;
        if (!chg_present_s || !ctrl_q[`CTRL_CHG_EN_BIT]) begin
            state_d = CHG_OFF;
        end else begin
            case (state_q)
                CHG_OFF, CHG_TRICKLE: begin
                    state_d = bat_low_s ? CHG_TRICKLE : CHG_FAST_CC;
                end
                CHG_FAST_CC: begin
                    if (bat_low_s) begin
                        state_d = CHG_TRICKLE;
                    end else if (bat_float_s) begin
                        state_d = CHG_FAST_CV;
                    end
                end
                CHG_FAST_CV: begin
                    if (bat_recharge_s) begin
                        state_d = CHG_FAST_CC;
                    end else if (!bat_float_s) begin
                        state_d = CHG_STANDBY;
                    end
                end
                CHG_STANDBY: begin
                    if (bat_recharge_s) begin
                        state_d = CHG_FAST_CC;
                    end
                end
                default: begin
                    state_d = CHG_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= CHG_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // ********************************
    // indicator pulse timer
    // ********************************
    logic [31:0] pulse_t_q;
    logic charging;
    assign charging = (state_q != CHG_OFF) && (state_q != CHG_STANDBY);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pulse_t_q <= 32'h0;
        end else if (pulse_t_q >= 32'(PULSE_PERIOD_CYCLES - 1)) begin
            pulse_t_q <= 32'h0;
        end else begin
            pulse_t_q <= pulse_t_q + 32'h1;
        end
    end

    // ********************************
    // outputs
    // ********************************
    logic smps_on_d, lin_on_d, pad0_on_d;
    assign smps_on_d = smps_pin2_q || ctrl_q[`CTRL_REG_LATCH_BIT]
                       || ctrl_q[`CTRL_SMPS_FW_BIT] || charging;
    assign lin_on_d = lin_pin_s || ctrl_q[`CTRL_REG_LATCH_BIT];
    assign pad0_on_d = led_fw_q[`LED0_FW_BIT] || (charging &&
                       (ctrl_q[`CTRL_FW_RUNNING_BIT] ||
                        pulse_t_q < 32'(PULSE_ON_CYCLES)));

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            smps_enable <= 1'b0;
            linear_reg_enable <= 1'b0;
            audio_reg_enable <= 1'b0;
            charge_trickle <= 1'b0;
            charge_cc <= 1'b0;
            charge_cv <= 1'b0;
            indicator_pad_0_out <= 1'b0;
            indicator_pad_0_oe_n <= 1'b1;
            indicator_pad_1_out <= 1'b0;
            indicator_pad_1_oe_n <= 1'b1;
            chip_reset <= 1'b1;
            warm_reset <= 1'b0;
            pads_in_reset <= 1'b1;
            safe_clock <= 1'b1;
        end else begin
            smps_enable <= smps_on_d;
            linear_reg_enable <= lin_on_d;
            audio_reg_enable <= lin_on_d;
            charge_trickle <= (state_q == CHG_TRICKLE);
            charge_cc <= (state_q == CHG_FAST_CC);
            charge_cv <= (state_q == CHG_FAST_CV);
            // pads only ever sink; in reset they float
            indicator_pad_0_out <= 1'b0;
            indicator_pad_0_oe_n <= int_reset || !pad0_on_d;
            indicator_pad_1_out <= 1'b0;
            indicator_pad_1_oe_n <= int_reset || !led_fw_q[`LED1_FW_BIT];
            chip_reset <= int_reset;
            warm_reset <= int_reset && soft_reset_q && !por_q;
            pads_in_reset <= int_reset;
            safe_clock <= int_reset || !ctrl_q[`CTRL_CLK_CONFIGURED_BIT];
        end
    end

    // ********************************
    // read port
    // ********************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 32'h0;
        end else if (!reg_rd) begin
            reg_rdata <= 32'h0;
        end else if (reg_addr == `REG_CTRL_ADDR) begin
            reg_rdata <= 32'(ctrl_q);
        end else if (reg_addr == `REG_STATUS_ADDR) begin
            reg_rdata <= 32'({bat_float_s, bat_low_s, soft_reset_q, state_q,
                              lin_on_d, smps_on_d, chg_present_s, lin_pin_s,
                              smps_pin2_q});
        end else if (reg_addr == `REG_LED_ADDR) begin
            reg_rdata <= 32'(led_fw_q);
        end else if (reg_addr == `REG_WDOG_ADDR) begin
            reg_rdata <= 32'(wdog_reload_q);
        end else if (reg_addr == `REG_WDOG_KICK_ADDR) begin
            reg_rdata <= 32'(wdog_cnt_q);
        end else if (reg_addr == `REG_RESET_CAUSE_ADDR) begin
            reg_rdata <= 32'(cause_q);
        end else if (reg_addr == `REG_ID_ADDR) begin
            reg_rdata <= ID_VALUE;
        end else begin
            reg_rdata <= 32'h0;
        end
    end

endmodule

// ===== prc_props.sv
/*
 * Concurrent checks on the ports of power_reset_charger_control.
 * Assumes one clock domain, ref_clk, with rst as its synchronous reset.
 */
`timescale 1ns/1ps

module prc_props (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // inputs watched
    input wire logic smps_enable_pin,
    input wire logic linear_reg_enable_pin,
    input wire logic charger_supply_in,
    input wire logic uart_break,
    // outputs watched
    input wire logic smps_enable,
    input wire logic linear_reg_enable,
    input wire logic audio_reg_enable,
    input wire logic charge_trickle,
    input wire logic charge_cc,
    input wire logic charge_cv,
    input wire logic indicator_pad_0_out,
    input wire logic indicator_pad_1_out,
    input wire logic chip_reset,
    input wire logic warm_reset,
    input wire logic pads_in_reset,
    input wire logic safe_clock
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // ****************
    // assertions
    // ****************
    reset_holds_a: assert property ($fell(rst) |-> chip_reset)
        else $error("internal reset not held after reset release");
    pads_follow_a: assert property (pads_in_reset == chip_reset)
        else $error("pad reset state differs from internal reset");
    clock_safe_a: assert property (chip_reset |-> safe_clock)
        else $error("safe clock low during reset");
    warm_in_reset_a: assert property (warm_reset |-> chip_reset)
        else $error("warm flag outside reset");
    break_reset_a: assert property ($rose(uart_break) |-> ##[1:6] chip_reset)
        else $error("break did not reset");
    supply_off_a: assert property (!charger_supply_in [*5] |->
        !(charge_trickle || charge_cc || charge_cv))
        else $error("charging without supply");
    state_onehot_a: assert property ($onehot0({charge_trickle, charge_cc, charge_cv}))
        else $error("charge modes overlap");
    smps_pin_a: assert property ((smps_enable_pin && !chip_reset) [*5] |-> smps_enable)
        else $error("switch-mode enable ignores pin");
    linear_pin_a: assert property ((linear_reg_enable_pin && !chip_reset) [*5] |->
        linear_reg_enable && audio_reg_enable)
        else $error("linear enables ignore pin");
    open_drain_a: assert property (!indicator_pad_0_out && !indicator_pad_1_out)
        else $error("pad driven high");
endmodule

bind power_reset_charger_control prc_props u_props (.ref_clk, .rst, .smps_enable_pin,
    .linear_reg_enable_pin, .charger_supply_in, .uart_break, .smps_enable, .linear_reg_enable,
    .audio_reg_enable, .charge_trickle, .charge_cc, .charge_cv, .indicator_pad_0_out,
    .indicator_pad_1_out, .chip_reset, .warm_reset, .pads_in_reset, .safe_clock);

// ===== battery_model.sv
/*
 * Behavioural charger supply and lithium cell: turns a commanded cell
 * voltage in millivolts into the comparator levels the block samples.
 * Assumes the bench changes commands just after a rising clock edge.
 */
`timescale 1ns/1ps

module battery_model #(
    parameter int FLOAT_MV = 4200,
    parameter int LOW_MV = 2900,
    parameter int MARGIN_MV = 150
) (
    // commands from the bench
    input wire logic supply_on,
    input wire logic [31:0] cell_mv,
    // comparator levels
    output logic charger_supply_in,
    output logic battery_below_low,
    output logic battery_at_float,
    output logic battery_below_recharge
);
    // ****************
    // comparators
    // ****************
    assign charger_supply_in = supply_on;
    assign battery_below_low = cell_mv < LOW_MV;
    assign battery_at_float = cell_mv >= FLOAT_MV;
    assign battery_below_recharge = cell_mv < FLOAT_MV - MARGIN_MV;
endmodule

// ===== power_reset_charger_control_test.sv
/*
 * Self-checking bench for power_reset_charger_control and its battery model.
 * Assumes shortened indicator pulse counts and the default reset filter.
 */
`timescale 1ns/1ps
`include "prc_regs.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end

module power_reset_charger_control_test
    import prc_pkg::*;
;
    logic ref_clk = 1'b0, rst = 1'b1, supply_on = 1'b0, rd_p = 1'b0;
    logic smps_enable_pin = 1'b0, linear_reg_enable_pin = 1'b0, rst_pin_n = 1'b1;
    logic slow_clk_tick = 1'b0, core_supply_low = 1'b0, core_supply_high = 1'b1;
    logic uart_break = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, cell_mv = 32'd3500;
    logic charger_supply_in, battery_below_low, battery_at_float, battery_below_recharge;
    logic smps_enable, linear_reg_enable, audio_reg_enable, charge_trickle, charge_cc;
    logic charge_cv, pad0_oe_n, pad1_oe_n, chip_reset, warm_reset, safe_clock;
    int fail_count = 0, checks_done = 0, seed = 32'hD29A;
    logic [31:0] exp_q [$];
    logic [31:0] exp_v;
    chg_state_t st_tab [6] = '{CHG_TRICKLE, CHG_FAST_CC, CHG_FAST_CV, CHG_STANDBY,
        CHG_FAST_CC, CHG_OFF};
    int mv_tab [6] = '{2500, 3500, 4200, 4150, 4000, 4000};
    logic [5:0] sup_tab = 6'h1F;

    always #5 ref_clk = ~ref_clk;

    power_reset_charger_control #(.PULSE_PERIOD_CYCLES(100), .PULSE_ON_CYCLES(10)) dut (
        .ref_clk, .rst, .smps_enable_pin, .linear_reg_enable_pin, .charger_supply_in,
        .battery_below_low, .battery_at_float, .battery_below_recharge, .rst_pin_n,
        .slow_clk_tick, .core_supply_low, .core_supply_high, .uart_break, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .smps_enable, .linear_reg_enable,
        .audio_reg_enable, .charge_trickle, .charge_cc, .charge_cv,
        .indicator_pad_0_out(), .indicator_pad_0_oe_n(pad0_oe_n), .indicator_pad_1_out(),
        .indicator_pad_1_oe_n(pad1_oe_n), .chip_reset, .warm_reset, .pads_in_reset(),
        .safe_clock);

    battery_model bat (.supply_on, .cell_mv, .charger_supply_in, .battery_below_low,
        .battery_at_float, .battery_below_recharge);

    // ****************
    // read data monitor
    // ****************
    always @(posedge ref_clk) rd_p <= reg_rd;
    always @(negedge ref_clk) begin
        if (rd_p) begin
            exp_v = exp_q.pop_front();
            `CHK(reg_rdata, exp_v)
        end
    end

    // ****************
    // bus and wait tasks
    // ****************
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask

    task automatic wait_rst(input logic v);
        int i;
        for (i = 0; i < 2000 && chip_reset !== v; i++) @(negedge ref_clk);
        if (chip_reset !== v) begin
            fail_count++;
            final_report();
        end
    endtask

    // latch or pins keep both regulators on wherever this is used
    function automatic logic [31:0] stat(input logic [2:0] st);
        return {21'h0, cell_mv >= 4200, cell_mv < 2900, 1'b0, st, 2'b11, supply_on,
            linear_reg_enable_pin, smps_enable_pin};
    endfunction

    task automatic final_report();
        if (fail_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge ref_clk);
        fail_count++;
        final_report();
    end

    // ****************
    // main sequence
    // ****************
    initial begin
        int i, n, ticks;
        logic [1:0] v;
        logic [2:0] oh;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        wait_rst(1'b0);
        rd(`REG_CTRL_ADDR, 32'h0000_0020);
        rd(`REG_RESET_CAUSE_ADDR, 32'h0000_0002);
        rd(8'h18, 32'h0000_0000);
        smps_enable_pin <= 1'b1;
        linear_reg_enable_pin <= 1'b1;
        repeat (6) @(posedge ref_clk);
        `CHK(smps_enable & linear_reg_enable & audio_reg_enable, 1'b1)
        rd(`REG_STATUS_ADDR, stat(CHG_OFF));
        wr(`REG_CTRL_ADDR, 32'h0000_0021);
        smps_enable_pin <= 1'b0;
        linear_reg_enable_pin <= 1'b0;
        repeat (6) @(posedge ref_clk);
        `CHK(smps_enable & linear_reg_enable, 1'b1)
        rd(`REG_STATUS_ADDR, stat(CHG_OFF));
        // low duty pulsing before firmware runs: one full period counted
        supply_on <= 1'b1;
        cell_mv <= 2500;
        repeat (8) @(posedge ref_clk);
        n = 0;
        for (i = 0; i < 100; i++) begin
            @(negedge ref_clk);
            n += (pad0_oe_n === 1'b0);
        end
        `CHK(n, 10)
        wr(`REG_CTRL_ADDR, 32'h0000_0037);
        for (i = 0; i < 6; i++) begin
            supply_on <= sup_tab[i];
            cell_mv <= mv_tab[i];
            repeat (8) @(posedge ref_clk);
            rd(`REG_STATUS_ADDR, stat(st_tab[i]));
            oh = {st_tab[i] == CHG_TRICKLE, st_tab[i] == CHG_FAST_CC, st_tab[i] == CHG_FAST_CV};
            `CHK({charge_trickle, charge_cc, charge_cv}, oh)
            `CHK(pad0_oe_n, ~|oh)
        end
        `CHK(safe_clock, 1'b0)
        for (i = 0; i < 4; i++) begin
            v = 2'($random(seed));
            wr(`REG_LED_ADDR, {30'h0, v});
            repeat (3) @(posedge ref_clk);
            `CHK({pad1_oe_n, pad0_oe_n}, ~v)
            rd(`REG_LED_ADDR, {30'h0, v});
        end
        wr(`REG_RESET_CAUSE_ADDR, 32'h0000_000F);
        rst_pin_n <= 1'b0;
        ticks = 0;
        for (i = 0; i < 400 && chip_reset !== 1'b1; i++) begin
            @(posedge ref_clk);
            slow_clk_tick <= (i % 40) >= 20;
            ticks += (i % 40 == 20);
            @(negedge ref_clk);
        end
        `CHK(ticks, 3)
        @(negedge ref_clk);
        `CHK(warm_reset, 1'b1)
        // held well past the recommended minimum in scaled ticks
        repeat (200) @(posedge ref_clk);
        rst_pin_n <= 1'b1;
        wait_rst(1'b0);
        rd(`REG_RESET_CAUSE_ADDR, 32'h0000_0001);
        rd(`REG_CTRL_ADDR, 32'h0000_0020);
        @(posedge ref_clk);
        uart_break <= 1'b1;
        wait_rst(1'b1);
        @(posedge ref_clk);
        uart_break <= 1'b0;
        wait_rst(1'b0);
        rd(`REG_RESET_CAUSE_ADDR, 32'h0000_0005);
        wr(`REG_WDOG_ADDR, 32'h0000_0040);
        wr(`REG_CTRL_ADDR, 32'h0000_0028);
        repeat (40) @(posedge ref_clk);
        wr(`REG_WDOG_KICK_ADDR, 32'h0000_0000);
        repeat (40) @(posedge ref_clk);
        `CHK(chip_reset, 1'b0)
        wait_rst(1'b1);
        wait_rst(1'b0);
        rd(`REG_RESET_CAUSE_ADDR, 32'h0000_000D);
        wr(`REG_RESET_CAUSE_ADDR, 32'h0000_000F);
        core_supply_high <= 1'b0;
        core_supply_low <= 1'b1;
        wait_rst(1'b1);
        `CHK(warm_reset, 1'b0)
        @(posedge ref_clk);
        core_supply_low <= 1'b0;
        core_supply_high <= 1'b1;
        wait_rst(1'b0);
        rd(`REG_RESET_CAUSE_ADDR, 32'h0000_0002);
        repeat (2) @(posedge ref_clk);
        final_report();
    end
endmodule
